// [include/ostc_regs.svh]
// Purpose: register offsets, field positions and reset values of the oscillator control block
// Assumes: 32-bit classic bus, one register per aligned word, at most 7 live bits each
// Notes: definitions only
`ifndef OSTC_REGS_SVH
`define OSTC_REGS_SVH

// ==========================================================================
// register byte offsets
`define OSTC_OFS_MAN_EN 8'h00
`define OSTC_OFS_FREQ 8'h04
`define OSTC_OFS_TRIM 8'h08
`define OSTC_OFS_TUNE 8'h0C
`define OSTC_OFS_SW_REQ 8'h10
`define OSTC_OFS_SW_CUR 8'h14
`define OSTC_OFS_SW_CTL 8'h18
`define OSTC_OFS_RDY 8'h1C

// ==========================================================================
// field positions
`define OSTC_MAN_EN_LSB 2
`define OSTC_MAN_EN_MSB 7
`define OSTC_TUNE_EN_BIT 7
`define OSTC_TUNE_PAUSE_BIT 6
`define OSTC_TUNE_LOCK_BIT 3
`define OSTC_TUNE_ORNG_BIT 1
`define OSTC_CTL_HOLD_BIT 7
`define OSTC_CTL_SPWR_BIT 6
`define OSTC_CTL_DONE_BIT 4
`define OSTC_CTL_NRDY_BIT 3
`define OSTC_RDY_PLL_BIT 0

// ==========================================================================
// masks of implemented bits, reset values and codes
`define OSTC_MASK_MAN_EN 8'hFC
`define OSTC_MASK_TUNE_W 8'hC0
`define OSTC_MASK_CTL_W 8'hC0
`define OSTC_RST_MAN_EN 8'h00
`define OSTC_RST_TUNE 2'h0
`define OSTC_RST_TRIM 6'h00
`define OSTC_RST_FREQ 3'h2
`define OSTC_FREQ_4MHZ 3'h2
`define OSTC_FREQ_32MHZ 3'h6
`define OSTC_FREQ_RSVD 3'h7
`define OSTC_SRC_EXT 3'h7
`define OSTC_SRC_FAST 3'h6
`define OSTC_SRC_SLOW 3'h5
`define OSTC_SRC_SEC 3'h4
`define OSTC_SRC_RSVD_HI 3'h3
`define OSTC_SRC_EXT_PLL 3'h2
`define OSTC_SRC_FAST_PLL 3'h1
`define OSTC_SRC_RSVD_LO 3'h0
`define OSTC_DIV_FAST4 4'h2
`define OSTC_DIV_ONE 4'h0
`define OSTC_TRIM_MAX 6'h1F
`define OSTC_TRIM_MIN 6'h20

`endif

// [include/ostc_pkg.sv]
// Purpose: shared types of the oscillator control block
// Assumes: nothing
// Notes: constants live in ostc_regs.svh
package ostc_pkg;
	typedef logic [2:0] ostc_src_t;
	typedef logic [3:0] ostc_div_t;
	typedef logic [5:0] ostc_trim_t;
	typedef enum logic [2:0] {
		OSTC_SW_IDLE = 3'h1,
		OSTC_SW_WAIT = 3'h2,
		OSTC_SW_HOLD = 3'h4
	} ostc_sw_state_t;
endpackage : ostc_pkg

// [include/ostc_tune_if.sv]
// Purpose: link between the register file and the automatic tuner
// Assumes: one clock domain
// Notes: ctl side owns enable, pause, event and the current trim
`timescale 1ns/1ps
interface ostc_tune_if #(parameter int ERR_W = 8);
	logic enable;
	logic pause;
	logic evt;
	logic signed [ERR_W-1:0] err;
	ostc_pkg::ostc_trim_t trim;
	logic upd;
	ostc_pkg::ostc_trim_t upd_val;
	logic locked;
	logic out_rng;
	modport ctl (output enable, pause, evt, err, trim, input upd, upd_val, locked, out_rng);
	modport tun (input enable, pause, evt, err, trim, output upd, upd_val, locked, out_rng);
endinterface : ostc_tune_if

// [verilog/ostc_tuner.sv]
// Purpose: automatic trim tuner for the fast internal oscillator
// Assumes: err is the signed frequency error at each tuning event, positive means too fast
// Notes: moves the trim at most one step per event toward the nominal frequency
`timescale 1ns/1ps
`include "ostc_regs.svh"
module ostc_tuner #(
	parameter int ERR_W = 8,
	parameter int LOCK_TOL = 2
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	ostc_tune_if.tun tun
);
	logic upd_r, upd_nxt;
	ostc_pkg::ostc_trim_t val_r, val_nxt;
	logic lock_r, lock_nxt;
	logic orng_r, orng_nxt;
	logic signed [ERR_W-1:0] tol;

	assign tol = ERR_W'(LOCK_TOL);

	// ==========================================================================
	// next state
	always_comb begin
		upd_nxt = 1'b0;
		val_nxt = val_r;
		lock_nxt = lock_r;
		orng_nxt = orng_r;
		if (!tun.enable) begin
			lock_nxt = 1'b0;
			orng_nxt = 1'b0;
		end else if (tun.evt) begin
			lock_nxt = (tun.err <= tol) && (tun.err >= -tol);
			orng_nxt = ((tun.err > tol) && (tun.trim == `OSTC_TRIM_MIN)) ||
				((tun.err < -tol) && (tun.trim == `OSTC_TRIM_MAX));
			if (!tun.pause && !lock_nxt && !orng_nxt) begin
				upd_nxt = 1'b1;
				val_nxt = (tun.err > 0) ? tun.trim - 6'h01 : tun.trim + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			upd_r <= 1'b0;
			val_r <= `OSTC_RST_TRIM;
			lock_r <= 1'b0;
			orng_r <= 1'b0;
		end else begin
			upd_r <= upd_nxt;
			val_r <= val_nxt;
			lock_r <= lock_nxt;
			orng_r <= orng_nxt;
		end
	end

	assign tun.upd = upd_r;
	assign tun.upd_val = val_r;
	assign tun.locked = lock_r;
	assign tun.out_rng = orng_r;
endmodule : ostc_tuner

// [verilog/ostc_top.sv]
// Purpose: oscillator enable, fast oscillator frequency and trim, clock switch registers
// Assumes: classic single-cycle bus master, straps stable after reset release
// Notes: straps are caught on the first clock edge after reset release
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ostc_regs.svh"
module ostc_top #(
	parameter int ADR_W = 8,
	parameter int REQ_W = 4,
	parameter int ERR_W = 8,
	parameter int LOCK_TOL = 2
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] reset_osc_config,
	input wire logic [2:0] ext_osc_config,
	input wire logic switch_write_enable,
	input wire logic [6*REQ_W-1:0] periph_req,
	input wire logic [5:0] osc_ready,
	input wire logic pll_ready,
	input wire logic tune_event,
	input wire logic signed [ERR_W-1:0] tune_error,
	output logic [5:0] osc_run_req,
	output logic [2:0] ext_osc_mode,
	output logic secondary_osc_power,
	output logic [2:0] fast_osc_freq_sel,
	output logic [5:0] fast_osc_freq_mhz,
	output logic [5:0] fast_osc_trim,
	output logic [2:0] current_source,
	output logic [3:0] current_divider,
	output logic switch_irq
);
	// oscillator vectors are {ext, fast, mid, slow, secondary, converter},
	// index i matching manual enable bit i+2

	// ==========================================================================
	// state
	logic init_r, init_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic [5:0] man_en_r, man_en_nxt;
	logic [2:0] freq_r, freq_nxt;
	ostc_pkg::ostc_trim_t trim_r, trim_nxt;
	logic [1:0] tctl_r, tctl_nxt;
	ostc_pkg::ostc_src_t req_src_r, req_src_nxt;
	ostc_pkg::ostc_div_t req_div_r, req_div_nxt;
	ostc_pkg::ostc_src_t cur_src_r, cur_src_nxt;
	ostc_pkg::ostc_div_t cur_div_r, cur_div_nxt;
	logic hold_r, hold_nxt;
	logic spwr_r, spwr_nxt;
	logic cwen_r, cwen_nxt;
	logic [2:0] extm_r, extm_nxt;
	logic irq_r, irq_nxt;
	logic [5:0] run_r, run_nxt;
	logic [5:0] mhz_r, mhz_nxt;
	ostc_pkg::ostc_sw_state_t sw_r, sw_nxt;

	logic [5:0] periph_any;
	logic req_rdy;
	logic sw_done;
	logic acc;
	logic wr;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;

	ostc_tune_if #(.ERR_W(ERR_W)) tif ();

	// ==========================================================================
	// decode helpers
	function automatic logic [5:0] src_mask(input ostc_pkg::ostc_src_t s);
		unique case (s)
			`OSTC_SRC_EXT, `OSTC_SRC_EXT_PLL: src_mask = 6'h20;
			`OSTC_SRC_SLOW: src_mask = 6'h04;
			`OSTC_SRC_SEC: src_mask = 6'h02;
			// reserved codes behave as the fast source
			default: src_mask = 6'h10;
		endcase
	endfunction : src_mask

	function automatic logic src_pll(input ostc_pkg::ostc_src_t s);
		src_pll = (s == `OSTC_SRC_EXT_PLL) || (s == `OSTC_SRC_FAST_PLL);
	endfunction : src_pll

	function automatic logic [5:0] freq_mhz(input logic [2:0] f);
		unique case (f)
			3'h0: freq_mhz = 6'h01;
			3'h1: freq_mhz = 6'h02;
			3'h2: freq_mhz = 6'h04;
			3'h3: freq_mhz = 6'h08;
			3'h4: freq_mhz = 6'h0C;
			3'h5: freq_mhz = 6'h10;
			3'h6: freq_mhz = 6'h20;
			default: freq_mhz = 6'h00;
		endcase
	endfunction : freq_mhz

	// ==========================================================================
	// peripheral request merge
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_req
			assign periph_any[gi] = |periph_req[gi*REQ_W +: REQ_W];
		end
	endgenerate

	assign req_rdy = |(src_mask(req_src_r) & osc_ready) && (!src_pll(req_src_r) || pll_ready);
	assign sw_done = (req_src_r == cur_src_r) && (req_div_r == cur_div_r);

	// ==========================================================================
	// tuner
	assign tif.enable = tctl_r[1];
	assign tif.pause = tctl_r[0];
	assign tif.evt = tune_event;
	assign tif.err = tune_error;
	assign tif.trim = trim_r;

	ostc_tuner #(.ERR_W(ERR_W), .LOCK_TOL(LOCK_TOL)) u_tuner (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.tun(tif)
	);

	// ==========================================================================
	// bus access and read mux
	assign acc = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];

	always_comb begin
		unique case (wb_adr_i)
			`OSTC_OFS_MAN_EN: rd_byte = {man_en_r, 2'h0};
			`OSTC_OFS_FREQ: rd_byte = {5'h00, freq_r};
			`OSTC_OFS_TRIM: rd_byte = {2'h0, trim_r};
			`OSTC_OFS_TUNE: rd_byte = {tctl_r, 2'h0, tif.locked, 1'b0, tif.out_rng, 1'b0};
			`OSTC_OFS_SW_REQ: rd_byte = {1'b0, req_src_r, req_div_r};
			`OSTC_OFS_SW_CUR: rd_byte = {1'b0, cur_src_r, cur_div_r};
			`OSTC_OFS_SW_CTL: rd_byte = {hold_r, spwr_r, 1'b0, sw_done,
				(sw_r != ostc_pkg::OSTC_SW_IDLE) && req_rdy, 3'h0};
			`OSTC_OFS_RDY: rd_byte = {osc_ready, 1'b0, pll_ready};
			default: rd_byte = 8'h00;
		endcase
	end

	// ==========================================================================
	// register and switch next state
	always_comb begin
		init_nxt = 1'b1;
		ack_nxt = acc;
		dat_nxt = acc ? {24'h000000, rd_byte} : dat_r;
		man_en_nxt = man_en_r;
		freq_nxt = freq_r;
		trim_nxt = trim_r;
		tctl_nxt = tctl_r;
		req_src_nxt = req_src_r;
		req_div_nxt = req_div_r;
		cur_src_nxt = cur_src_r;
		cur_div_nxt = cur_div_r;
		hold_nxt = hold_r;
		spwr_nxt = spwr_r;
		cwen_nxt = cwen_r;
		extm_nxt = extm_r;
		irq_nxt = irq_r;
		sw_nxt = sw_r;

		if (!init_r) begin
			if (reset_osc_config == `OSTC_SRC_FAST)
				freq_nxt = `OSTC_FREQ_4MHZ;
			else if (reset_osc_config == `OSTC_SRC_RSVD_LO)
				freq_nxt = `OSTC_FREQ_32MHZ;
			req_src_nxt = reset_osc_config;
			req_div_nxt = (reset_osc_config == `OSTC_SRC_FAST) ? `OSTC_DIV_FAST4 : `OSTC_DIV_ONE;
			cur_src_nxt = req_src_nxt;
			cur_div_nxt = req_div_nxt;
			cwen_nxt = switch_write_enable;
			extm_nxt = ext_osc_config;
		end else begin
			if (wr) begin
				unique case (wb_adr_i)
					`OSTC_OFS_MAN_EN: man_en_nxt = wbyte[`OSTC_MAN_EN_MSB:`OSTC_MAN_EN_LSB];
					`OSTC_OFS_FREQ: begin
						// reserved frequency code leaves the select unchanged
						if (wbyte[2:0] != `OSTC_FREQ_RSVD)
							freq_nxt = wbyte[2:0];
					end
					`OSTC_OFS_TRIM: begin
						if (!tctl_r[1] && !tctl_r[0])
							trim_nxt = wbyte[5:0];
					end
					`OSTC_OFS_TUNE: tctl_nxt = wbyte[`OSTC_TUNE_EN_BIT:`OSTC_TUNE_PAUSE_BIT];
					`OSTC_OFS_SW_REQ: begin
						if (cwen_r && wbyte[6:4] != `OSTC_SRC_RSVD_HI &&
							wbyte[6:4] != `OSTC_SRC_RSVD_LO) begin
							req_src_nxt = wbyte[6:4];
							req_div_nxt = wbyte[3:0];
						end
					end
					`OSTC_OFS_SW_CTL: begin
						hold_nxt = wbyte[`OSTC_CTL_HOLD_BIT];
						spwr_nxt = wbyte[`OSTC_CTL_SPWR_BIT];
					end
					default: ;
				endcase
			end
			if (tif.upd && tctl_r[1] && !tctl_r[0])
				trim_nxt = tif.upd_val;

			unique case (sw_r)
				ostc_pkg::OSTC_SW_IDLE: begin
					if (!sw_done)
						sw_nxt = ostc_pkg::OSTC_SW_WAIT;
				end
				ostc_pkg::OSTC_SW_WAIT: begin
					if (sw_done) begin
						sw_nxt = ostc_pkg::OSTC_SW_IDLE;
					end else if (req_rdy && hold_r) begin
						sw_nxt = ostc_pkg::OSTC_SW_HOLD;
						irq_nxt = 1'b1;
					end else if (req_rdy) begin
						cur_src_nxt = req_src_r;
						cur_div_nxt = req_div_r;
						sw_nxt = ostc_pkg::OSTC_SW_IDLE;
					end
				end
				ostc_pkg::OSTC_SW_HOLD: begin
					if (!hold_r || sw_done) begin
						cur_src_nxt = req_src_r;
						cur_div_nxt = req_div_r;
						irq_nxt = 1'b0;
						sw_nxt = ostc_pkg::OSTC_SW_IDLE;
					end
				end
			endcase
		end
	end

	always_comb begin
		run_nxt = man_en_r | periph_any | src_mask(cur_src_r);
		// the oscillator being switched to must start before it can report ready
		if (sw_r != ostc_pkg::OSTC_SW_IDLE)
			run_nxt = run_nxt | src_mask(req_src_r);
		mhz_nxt = freq_mhz(freq_r);
	end

	// ==========================================================================
	// registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			init_r <= 1'b0;
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
			man_en_r <= 6'h00;
			freq_r <= `OSTC_RST_FREQ;
			trim_r <= `OSTC_RST_TRIM;
			tctl_r <= `OSTC_RST_TUNE;
			req_src_r <= `OSTC_SRC_FAST;
			req_div_r <= `OSTC_DIV_ONE;
			cur_src_r <= `OSTC_SRC_FAST;
			cur_div_r <= `OSTC_DIV_ONE;
			hold_r <= 1'b0;
			spwr_r <= 1'b0;
			cwen_r <= 1'b0;
			extm_r <= 3'h0;
			irq_r <= 1'b0;
			run_r <= 6'h00;
			mhz_r <= 6'h00;
			sw_r <= ostc_pkg::OSTC_SW_IDLE;
		end else begin
			init_r <= init_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			man_en_r <= man_en_nxt;
			freq_r <= freq_nxt;
			trim_r <= trim_nxt;
			tctl_r <= tctl_nxt;
			req_src_r <= req_src_nxt;
			req_div_r <= req_div_nxt;
			cur_src_r <= cur_src_nxt;
			cur_div_r <= cur_div_nxt;
			hold_r <= hold_nxt;
			spwr_r <= spwr_nxt;
			cwen_r <= cwen_nxt;
			extm_r <= extm_nxt;
			irq_r <= irq_nxt;
			run_r <= run_nxt;
			mhz_r <= mhz_nxt;
			sw_r <= sw_nxt;
		end
	end

	// ==========================================================================
	// outputs
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign osc_run_req = run_r;
	assign ext_osc_mode = extm_r;
	assign secondary_osc_power = spwr_r;
	assign fast_osc_freq_sel = freq_r;
	assign fast_osc_freq_mhz = mhz_r;
	assign fast_osc_trim = trim_r;
	assign current_source = cur_src_r;
	assign current_divider = cur_div_r;
	assign switch_irq = irq_r;
endmodule : ostc_top

// [testbench/ostc_top_asserts.sv]
// Purpose: concurrent checks on the oscillator control ports
// Assumes: one clock, byte data in lane 0, tuner mode seen through bus writes
// Notes: tuner enable and pause are mirrored from writes, not read from the design
`timescale 1ns/1ps
module ostc_top_chk #(
	parameter int ADR_W = 8,
	parameter int REQ_W = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [2:0] reset_osc_config,
	input wire logic [6*REQ_W-1:0] periph_req,
	input wire logic tune_event,
	input wire logic [5:0] osc_run_req,
	input wire logic [2:0] fast_osc_freq_sel,
	input wire logic [5:0] fast_osc_freq_mhz,
	input wire logic [5:0] fast_osc_trim
);
	// ==========================================================
	// helper logic
	localparam logic [41:0] MHZ_TAB = {6'h20, 6'h10, 6'h0C, 6'h08, 6'h04, 6'h02, 6'h01};
	logic tk, wr_man, wr_trim, wr_tun, en_r, en_nxt, pz_r, pz_nxt;
	assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_man = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h00);
	assign wr_trim = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h08);
	assign wr_tun = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h0C);
	always_comb begin
		en_nxt = en_r;
		pz_nxt = pz_r;
		if (wr_tun) begin
			en_nxt = wb_dat_i[7];
			pz_nxt = wb_dat_i[6];
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			en_r <= 1'b0;
			pz_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			pz_r <= pz_nxt;
		end
	end
	function automatic logic [5:0] mhz(input logic [2:0] c);
		return MHZ_TAB[6*int'(c) +: 6];
	endfunction : mhz
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	ack_after_req_a: assert property (tk |=> wb_ack_o)
		else $error("bus request not answered");
	rsvd_read_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0 &&
		(wb_adr_i != 8'h00 || wb_dat_o[1:0] == 2'h0)) else $error("unused bits read nonzero");
	for (genvar i = 0; i < 6; i++) begin : g_osc
		force_run_a: assert property (wr_man && wb_dat_i[i+2] |=> ##1 osc_run_req[i])
			else $error("forced oscillator not requested");
		periph_run_a: assert property (|periph_req[i*REQ_W +: REQ_W] |=> osc_run_req[i])
			else $error("peripheral request not passed on");
	end
	freq_decode_a: assert property (!$past(sys_rst) |->
		fast_osc_freq_mhz == mhz($past(fast_osc_freq_sel))) else $error("wrong frequency decode");
	freq_reset_a: assert property ($past(sys_rst) |=>
		fast_osc_freq_sel == ((reset_osc_config == 3'h0) ? 3'h6 : 3'h2)) else $error("bad freq default");
	trim_frozen_a: assert property ((en_r && !tune_event && !$past(tune_event) &&
		!$past(tune_event, 2)) || (pz_r && $past(pz_r) && $past(pz_r, 2)) |=> $stable(fast_osc_trim))
		else $error("trim moved while frozen");
	trim_step_a: assert property (!$stable(fast_osc_trim) && !$past(wr_trim) |->
		6'(fast_osc_trim - $past(fast_osc_trim)) inside {6'h01, 6'h3F}) else $error("tuner step not one");
	cover property (wr_trim && en_r);
	cover property (tune_event && en_r && !pz_r);
	cover property ($rose(osc_run_req[2]));
endmodule : ostc_top_chk

bind ostc_top ostc_top_chk #(.ADR_W(ADR_W), .REQ_W(REQ_W)) u_chk (.clk_sys, .sys_rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_osc_config,
	.periph_req, .tune_event, .osc_run_req, .fast_osc_freq_sel, .fast_osc_freq_mhz, .fast_osc_trim);

// [testbench/ostc_top_test.sv]
// Purpose: self-checking bench of the oscillator control block
// Assumes: one bus answer per request, tuner events driven by hand
// Notes: straps change only while reset is held
`timescale 1ns/1ps
module ostc_top_test;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o, switch_irq, secondary_osc_power;
	logic [2:0] reset_osc_config = 3'h6;
	logic [2:0] ext_osc_config = 3'h1;
	logic switch_write_enable = 1'b1;
	logic [23:0] periph_req = 24'h0;
	// slow oscillator starts not ready so a switch to it must wait
	logic [5:0] osc_ready = 6'h3B;
	logic tune_event = 1'b0;
	logic signed [7:0] tune_error = 8'sh00;
	logic [5:0] osc_run_req, fast_osc_freq_mhz, fast_osc_trim;
	logic [2:0] fast_osc_freq_sel, current_source, ext_osc_mode;
	logic [3:0] current_divider;
	int error_cnt = 0;
	int n_compared = 0;
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	ostc_top uut (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_osc_config,
		.ext_osc_config, .switch_write_enable, .periph_req, .osc_ready,
		.pll_ready(1'b1), .tune_event, .tune_error, .osc_run_req, .ext_osc_mode,
		.secondary_osc_power, .fast_osc_freq_sel, .fast_osc_freq_mhz, .fast_osc_trim,
		.current_source, .current_divider, .switch_irq);
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 40) chk("ack", 32'h0, 32'h1);
	endtask : wb
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(nm, q, {24'h0, e});
	endtask : rc
	task automatic rst(input logic [2:0] st, input logic sw, input logic [2:0] xm);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		reset_osc_config <= st;
		ext_osc_config <= xm;
		switch_write_enable <= sw;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : rst
	task automatic ev(input logic signed [7:0] e);
		@(posedge clk_sys);
		tune_event <= 1'b1;
		tune_error <= e;
		@(posedge clk_sys);
		tune_event <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : ev
	// ==========================================================
	// scenarios
	task automatic t_force;
		chk("ext mode", ext_osc_mode, 32'h1);
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, 8'h00, 8'h04 << i);
			rc("enable", 8'h00, 8'h04 << i);
			chk("run req", osc_run_req, 32'(6'h10 | (6'h01 << i)));
		end
		wb(1'b1, 8'h00, 8'hFF);
		rc("enable all", 8'h00, 8'hFC);
		wb(1'b1, 8'h00, 8'h00);
		periph_req <= 24'h000100;
		repeat (3) @(posedge clk_sys);
		chk("periph run", osc_run_req, 32'h14);
		periph_req <= 24'h0;
	endtask : t_force
	task automatic t_freq;
		logic [5:0] tab [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20};
		rc("freq rst", 8'h04, 8'h02);
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, 8'h04, 8'(i));
			rc("freq", 8'h04, 8'(i));
			chk("mhz", fast_osc_freq_mhz, 32'(tab[i]));
		end
		wb(1'b1, 8'h04, 8'hFF);
		rc("freq code 7", 8'h04, 8'h06);
		rc("unmapped", 8'h20, 8'h00);
	endtask : t_freq
	task automatic t_trim;
		rc("trim rst", 8'h08, 8'h00);
		wb(1'b1, 8'h08, 8'hFF);
		rc("trim", 8'h08, 8'h3F);
		wb(1'b1, 8'h08, 8'h20);
		wb(1'b1, 8'h0C, 8'hBF);
		rc("tuner ctl", 8'h0C, 8'h80);
		wb(1'b1, 8'h08, 8'h05);
		rc("trim owned", 8'h08, 8'h20);
		ev(8'sd10);
		rc("out of range", 8'h0C, 8'h82);
		chk("trim min", fast_osc_trim, 32'h20);
		ev(8'sd0);
		rc("locked", 8'h0C, 8'h88);
		ev(-8'sd10);
		chk("trim step", fast_osc_trim, 32'h21);
		wb(1'b1, 8'h0C, 8'hC0);
		ev(-8'sd10);
		rc("tuner paused", 8'h08, 8'h21);
		wb(1'b1, 8'h0C, 8'h40);
		wb(1'b1, 8'h08, 8'h05);
		rc("write paused", 8'h08, 8'h21);
		wb(1'b1, 8'h0C, 8'h00);
		wb(1'b1, 8'h08, 8'h05);
		rc("trim free", 8'h08, 8'h05);
	endtask : t_trim
	task automatic t_switch;
		wb(1'b1, 8'h10, 8'h35);
		rc("reserved source", 8'h10, 8'h62);
		wb(1'b1, 8'h18, 8'hC0);
		wb(1'b1, 8'h10, 8'h50);
		rc("switch wait", 8'h18, 8'hC0);
		chk("sec power", secondary_osc_power, 32'h1);
		chk("run wait", osc_run_req, 32'h14);
		osc_ready <= 6'h3F;
		repeat (4) @(posedge clk_sys);
		chk("irq held", switch_irq, 32'h1);
		chk("source held", current_source, 32'h6);
		rc("switch held", 8'h18, 8'hC8);
		rc("ready status", 8'h1C, 8'hFD);
		wb(1'b1, 8'h18, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk("irq clear", switch_irq, 32'h0);
		chk("sec power off", secondary_osc_power, 32'h0);
		chk("divider", current_divider, 32'h0);
		rc("switch done", 8'h18, 8'h10);
		rc("current", 8'h14, 8'h50);
		wb(1'b1, 8'h10, 8'h62);
		repeat (4) @(posedge clk_sys);
		chk("no hold", current_source, 32'h6);
	endtask : t_switch
	task automatic t_lock;
		rst(3'h0, 1'b0, 3'h5);
		rc("freq strap", 8'h04, 8'h06);
		chk("ext mode strap", ext_osc_mode, 32'h5);
		wb(1'b1, 8'h10, 8'h50);
		rc("request fixed", 8'h10, 8'h00);
	endtask : t_lock
	// ==========================================================
	// run control
	task automatic end_of_test;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	initial begin
		rst(3'h6, 1'b1, 3'h1);
		t_force;
		t_freq;
		t_trim;
		t_switch;
		t_lock;
		end_of_test;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		end_of_test;
	end
endmodule : ostc_top_test
